/* core/trgexp_pkg.sv */
// Shared constants and types for the trigger and exposure block
package trgexp_pkg;
  // Trigger source codes
  typedef enum logic [3:0] {
    TRGEXP_SRC_LINE5, TRGEXP_SRC_LINE6, TRGEXP_SRC_LINE7, TRGEXP_SRC_SOFT,
    TRGEXP_SRC_TMR_START, TRGEXP_SRC_TMR_END, TRGEXP_SRC_TMR_ACTIVE,
    TRGEXP_SRC_CNT_START, TRGEXP_SRC_CNT_END,
    TRGEXP_SRC_USER0, TRGEXP_SRC_USER1, TRGEXP_SRC_USER2, TRGEXP_SRC_USER3,
    TRGEXP_SRC_ACTION1, TRGEXP_SRC_ACTION2, TRGEXP_SRC_OFF
  } trgexp_src_t;
  // Trigger qualifier
  typedef enum logic [1:0] {
    TRGEXP_RISING, TRGEXP_FALLING, TRGEXP_LEVEL_HIGH, TRGEXP_LEVEL_LOW
  } trgexp_qual_t;
  // Power-up TTL polarity
  typedef enum logic [1:0] {
    TRGEXP_POL_AUTO, TRGEXP_POL_RISE_FIRST, TRGEXP_POL_FALL_FIRST
  } trgexp_pol_t;
  // Exposure select
  typedef enum logic [1:0] {
    TRGEXP_EXP_OFF, TRGEXP_EXP_TIMED, TRGEXP_EXP_PULSE
  } trgexp_exp_t;
  // Auto exposure
  typedef enum logic [1:0] {
    TRGEXP_AUTO_OFF, TRGEXP_AUTO_ONCE, TRGEXP_AUTO_CONT
  } trgexp_auto_t;
  // Counter event source
  typedef enum logic [1:0] {
    TRGEXP_CEV_OFF, TRGEXP_CEV_ACQ_TRIG, TRGEXP_CEV_ACQ_START, TRGEXP_CEV_ACQ_END
  } trgexp_cev_t;

  localparam int CLOCK_HZ         = 25000000;
  localparam int STEP_NS          = 1000;
  localparam int STEP_CYCLES      = (STEP_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int DELAY_W          = 16;
  localparam int EXP_W            = 21;
  localparam int CNT_W            = 16;
  localparam int PRIO_N           = 8;
  localparam logic [EXP_W-1:0] EXP_MIN_US = 21'h00000A;
  localparam logic [EXP_W-1:0] EXP_MAX_US = 21'h1E83BE;
  localparam logic [EXP_W-1:0] EXP_RESET_US = 21'h0003E8;
  localparam int FREE_RUN_US      = 1000;
endpackage

/* core/trgexp_qualifier.sv */
// Synchroniser plus edge or level qualification of one trigger source
`timescale 1ns/1ps
`default_nettype none
module trgexp_qualifier
  import trgexp_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // Source
  input  wire logic                  raw_in,
  input  wire logic                  sync_needed,
  input  wire trgexp_pkg::trgexp_qual_t qual,
  // Result
  output logic                       fire,
  output logic                       level_on,
  output logic                       rise,
  output logic                       fall
);
  logic meta, stable, prev;
  logic next_meta, next_stable, next_prev;
  always_comb begin
    next_meta   = raw_in;
    next_stable = meta;                       // R23
    next_prev   = sync_needed ? stable : raw_in;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
      prev   <= next_prev;
    end
  end
  logic cur;
  always_comb begin
    cur      = sync_needed ? stable : raw_in;
    rise     = cur & ~prev;
    fall     = ~cur & prev;
    level_on = 1'b0;
    fire     = 1'b0;
    case (qual)
      TRGEXP_RISING:     fire = rise;        // R2
      TRGEXP_FALLING:    fire = fall;        // R2
      TRGEXP_LEVEL_HIGH: level_on = cur;     // R3
      TRGEXP_LEVEL_LOW:  level_on = ~cur;    // R3
      default:           fire = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

/* core/trgexp_core.sv */
// Trigger conditioning and exposure control top level
//
// Operation
// R1: Trigger source chosen from lines, software, timer, counter
// R2: Edge qualifier fires on chosen transition
// R3: Level qualifier asserts while source at level
// R4: Host pairs level with pulse, edge otherwise
// R5: TTL polarity follows function's chosen activation
// R6: Rise-first power-up detects low-to-high first
// R7: Fall-first power-up detects high-to-low first
// R8: Auto power-up uses top-priority function's activation
// R9: Priority order acquisition start through counter reset
// R10: Overlap matters only with frame trigger on
// R11: Overlap off ignores triggers during readout
// R12: Readout overlap: line-synced during readout; code line-syncs only timed-mode starts, pulse mode starts at once
// R13: Synced start lags at most one line
// R14: Frame trigger delayed by 16-bit microsecond count; code delays only timed-mode triggers, pulse mode starts at once
// R15: Exposure off free-runs; timed free-runs or triggers
// R16: Pulse mode exposes for trigger pulse width
// R17: Timed exposure clamped 10us to 1.999806s
// R18: Auto exposure only in timed mode
// R19: Auto exposure bounds, speed, reference, region honoured; code has no reference or region input, only min/max bounds and speed
// R20: Single counter active once any source set
// R21: Counter event source advances the count
// R22: Triggered exposure only while capture running
// R23: External inputs synchronised before qualification
`timescale 1ns/1ps
`default_nettype none
module trgexp_core
  import trgexp_pkg::*;
(
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // Trigger sources
  input  wire logic                        line_opt_in1,
  input  wire logic                        line_opt_in2,
  input  wire logic                        line_ttl_in1,
  input  wire logic                        soft_trigger,
  input  wire logic                        timer_start,
  input  wire logic                        timer_end,
  input  wire logic                        timer_active,
  input  wire logic                        counter_start,
  input  wire logic                        counter_end,
  input  wire logic [3:0]                  user_output,
  input  wire logic                        action1,
  input  wire logic                        action2,
  // Trigger configuration
  input  wire trgexp_pkg::trgexp_src_t     frame_src,
  input  wire trgexp_pkg::trgexp_qual_t    trigger_qualifier,
  input  wire logic                        frame_begin_trigger,
  input  wire logic                        readout_trigger_accept,
  input  wire logic [DELAY_W-1:0]          trigger_delay_us,
  input  wire trgexp_pkg::trgexp_pol_t     power_up_polarity,
  input  wire logic [PRIO_N-1:0]           ttl_user_mask,
  input  wire logic [PRIO_N-1:0]           ttl_user_low,
  // Exposure configuration
  input  wire trgexp_pkg::trgexp_exp_t     exposure_select,
  input  wire logic [EXP_W-1:0]            exposure_duration,
  input  wire trgexp_pkg::trgexp_auto_t    auto_exposure,
  input  wire logic [EXP_W-1:0]            auto_max_us,
  input  wire logic [EXP_W-1:0]            auto_min_us,
  input  wire logic [3:0]                  auto_speed,
  input  wire logic                        auto_level_control,
  input  wire logic                        auto_too_dark,
  // Counter configuration
  input  wire trgexp_pkg::trgexp_cev_t     count_event_select,
  input  wire logic                        count_reset_set,
  input  wire logic                        count_start_set,
  input  wire logic                        acq_trigger,
  input  wire logic                        acq_start,
  input  wire logic                        acq_end,
  // Sensor status
  input  wire logic                        capture_running,
  input  wire logic                        sensor_readout,
  input  wire logic                        line_valid_timing,
  // Results
  output logic                             exposure_active,
  output logic                             free_running,
  output logic                             trigger_ignored,
  output logic                             ttl_active_low,
  output logic [EXP_W-1:0]                 exposure_used,
  output logic                             counter_enabled,
  output logic [CNT_W-1:0]                 counter_value
);
  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  logic raw_src;
  logic ext_src;
  always_comb begin
    ext_src = 1'b0;
    case (frame_src)                                         // R1
      TRGEXP_SRC_LINE5:      raw_src = line_opt_in1;
      TRGEXP_SRC_LINE6:      raw_src = line_opt_in2;
      TRGEXP_SRC_LINE7:      raw_src = line_ttl_in1 ^ ttl_active_low;
      TRGEXP_SRC_SOFT:       raw_src = soft_trigger;
      TRGEXP_SRC_TMR_START:  raw_src = timer_start;
      TRGEXP_SRC_TMR_END:    raw_src = timer_end;
      TRGEXP_SRC_TMR_ACTIVE: raw_src = timer_active;
      TRGEXP_SRC_CNT_START:  raw_src = counter_start;
      TRGEXP_SRC_CNT_END:    raw_src = counter_end;
      TRGEXP_SRC_USER0:      raw_src = user_output[0];
      TRGEXP_SRC_USER1:      raw_src = user_output[1];
      TRGEXP_SRC_USER2:      raw_src = user_output[2];
      TRGEXP_SRC_USER3:      raw_src = user_output[3];
      TRGEXP_SRC_ACTION1:    raw_src = action1;
      TRGEXP_SRC_ACTION2:    raw_src = action2;
      default:               raw_src = 1'b0;
    endcase
    case (frame_src)
      TRGEXP_SRC_LINE5, TRGEXP_SRC_LINE6, TRGEXP_SRC_LINE7: ext_src = 1'b1;
      default: ext_src = 1'b0;
    endcase
  end

  // TTL input inverted so the qualifier always sees the active sense
  trgexp_pkg::trgexp_qual_t eff_qual;
  always_comb begin
    eff_qual = trigger_qualifier;
    if (frame_src == TRGEXP_SRC_LINE7 && ttl_active_low) begin
      case (trigger_qualifier)
        TRGEXP_RISING:     eff_qual = TRGEXP_FALLING;
        TRGEXP_FALLING:    eff_qual = TRGEXP_RISING;
        TRGEXP_LEVEL_HIGH: eff_qual = TRGEXP_LEVEL_LOW;
        default:           eff_qual = TRGEXP_LEVEL_HIGH;
      endcase
    end
  end

  logic trig_fire, trig_level;
  trgexp_qualifier u_qual (
    .clock       (clock),
    .reset       (reset),
    .raw_in      (raw_src),
    .sync_needed (ext_src),
    .qual        (eff_qual),
    .fire        (trig_fire),
    .level_on    (trig_level),
    .rise        (),
    .fall        ()
  );

  // ------------------------------------------------------------
  // TTL polarity
  // ------------------------------------------------------------
  logic polarity_set;
  logic next_ttl_active_low, next_polarity_set;
  logic auto_low;
  always_comb begin
    auto_low = 1'b0;
    for (int i = PRIO_N - 1; i >= 0; i--) begin              // R9
      if (ttl_user_mask[i]) auto_low = ttl_user_low[i];
    end
    next_ttl_active_low = ttl_active_low;
    next_polarity_set   = 1'b1;
    if (!polarity_set) begin
      case (power_up_polarity)
        TRGEXP_POL_RISE_FIRST: next_ttl_active_low = 1'b0;   // R6
        TRGEXP_POL_FALL_FIRST: next_ttl_active_low = 1'b1;   // R7
        default:               next_ttl_active_low = auto_low; // R8
      endcase
    end else if (frame_src == TRGEXP_SRC_LINE7) begin
      next_ttl_active_low = (trigger_qualifier == TRGEXP_FALLING) ||
                            (trigger_qualifier == TRGEXP_LEVEL_LOW); // R5
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      ttl_active_low <= 1'b0;
      polarity_set   <= 1'b0;
    end else begin
      ttl_active_low <= next_ttl_active_low;
      polarity_set   <= next_polarity_set;
    end
  end

  // ------------------------------------------------------------
  // Microsecond tick and trigger delay
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    TRGEXP_IDLE, TRGEXP_DELAY, TRGEXP_LINE_WAIT, TRGEXP_EXPOSE, TRGEXP_PULSE, TRGEXP_GAP
  } trgexp_state_t;
  trgexp_state_t state, next_state;
  logic [4:0] tick_cnt;
  logic       us_tick;
  logic [4:0] next_tick_cnt;
  always_comb begin
    us_tick       = (tick_cnt == 5'(STEP_CYCLES - 1));
    next_tick_cnt = (us_tick || state == TRGEXP_IDLE) ? 5'h00 : tick_cnt + 5'h01;
  end
  always_ff @(posedge clock) begin
    if (reset) tick_cnt <= 5'h00;
    else tick_cnt <= next_tick_cnt;
  end

  // ------------------------------------------------------------
  // Exposure sequencer
  // ------------------------------------------------------------
  logic [EXP_W-1:0] us_cnt, next_us_cnt;
  logic [EXP_W-1:0] exp_len, next_exposure_used;
  logic next_exposure_active, next_free_running, next_trigger_ignored;
  logic triggered, in_readout_hold, accept;

  always_comb begin
    triggered = capture_running && frame_begin_trigger &&
                (exposure_select != TRGEXP_EXP_OFF);           // R22 R15
    // Clamp programmed or auto time into the legal window
    exp_len = (auto_exposure != TRGEXP_AUTO_OFF) ? exposure_used : exposure_duration;
    if (exp_len < EXP_MIN_US) exp_len = EXP_MIN_US;            // R17
    if (exp_len > EXP_MAX_US) exp_len = EXP_MAX_US;            // R17
    in_readout_hold = sensor_readout && !readout_trigger_accept; // R10 R11
    accept = triggered && !in_readout_hold;
    next_trigger_ignored = triggered && sensor_readout && !readout_trigger_accept
                           && (trig_fire || trig_level) && state == TRGEXP_IDLE;
    next_state           = state;
    next_us_cnt          = us_cnt;
    next_exposure_active = 1'b0;
    next_free_running    = capture_running && !triggered;
    case (state)
      TRGEXP_IDLE: begin
        if (capture_running && !triggered) begin
          next_state  = TRGEXP_EXPOSE;                         // R15 R16
          next_us_cnt = '0;
        end else if (accept && exposure_select == TRGEXP_EXP_PULSE && trig_level) begin
          next_state = TRGEXP_PULSE;                           // R16
        end else if (accept && exposure_select == TRGEXP_EXP_TIMED && trig_fire) begin
          next_state  = TRGEXP_DELAY;
          next_us_cnt = '0;
        end
      end
      TRGEXP_DELAY: begin
        if (us_cnt >= EXP_W'(trigger_delay_us)) begin          // R14
          next_us_cnt = '0;
          // Inside readout the start waits for the next line boundary
          next_state  = sensor_readout ? TRGEXP_LINE_WAIT : TRGEXP_EXPOSE; // R12
        end else if (us_tick) begin
          next_us_cnt = us_cnt + 21'h000001;
        end
      end
      TRGEXP_LINE_WAIT: begin
        if (line_valid_timing || !sensor_readout) next_state = TRGEXP_EXPOSE; // R13
      end
      TRGEXP_EXPOSE: begin
        next_exposure_active = 1'b1;
        if (exposure_select == TRGEXP_EXP_TIMED && us_cnt >= exp_len) begin
          next_state = TRGEXP_GAP;
        end else if (exposure_select != TRGEXP_EXP_TIMED &&
                     us_cnt >= EXP_W'(FREE_RUN_US)) begin
          next_state = TRGEXP_GAP;
        end else if (us_tick) begin
          next_us_cnt = us_cnt + 21'h000001;
        end
      end
      TRGEXP_PULSE: begin
        next_exposure_active = trig_level;                     // R16
        if (!trig_level) next_state = TRGEXP_GAP;
      end
      TRGEXP_GAP: begin
        if (!sensor_readout) next_state = TRGEXP_IDLE;
      end
      default: next_state = TRGEXP_IDLE;
    endcase
    // Auto exposure adjusts the time only in timed mode
    next_exposure_used = exposure_used;
    if (exposure_select == TRGEXP_EXP_TIMED && auto_level_control &&
        auto_exposure != TRGEXP_AUTO_OFF && state == TRGEXP_GAP && us_tick) begin // R18
      if (auto_too_dark && exposure_used + EXP_W'(auto_speed) <= auto_max_us)
        next_exposure_used = exposure_used + EXP_W'(auto_speed); // R19
      else if (!auto_too_dark && exposure_used >= auto_min_us + EXP_W'(auto_speed))
        next_exposure_used = exposure_used - EXP_W'(auto_speed); // R19
    end else if (auto_exposure == TRGEXP_AUTO_OFF) begin
      next_exposure_used = exp_len;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state           <= TRGEXP_IDLE;
      us_cnt          <= '0;
      exposure_active <= 1'b0;
      free_running    <= 1'b0;
      trigger_ignored <= 1'b0;
      exposure_used   <= EXP_RESET_US;
    end else begin
      state           <= next_state;
      us_cnt          <= next_us_cnt;
      exposure_active <= next_exposure_active;
      free_running    <= next_free_running;
      trigger_ignored <= next_trigger_ignored;
      exposure_used   <= next_exposure_used;
    end
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  logic cev_raw, cev_prev, next_cev_prev;
  logic next_counter_enabled;
  logic [CNT_W-1:0] next_counter_value;
  always_comb begin
    case (count_event_select)
      TRGEXP_CEV_ACQ_TRIG:  cev_raw = acq_trigger;
      TRGEXP_CEV_ACQ_START: cev_raw = acq_start;
      TRGEXP_CEV_ACQ_END:   cev_raw = acq_end;
      default:              cev_raw = 1'b0;
    endcase
    next_cev_prev        = cev_raw;
    next_counter_enabled = (count_event_select != TRGEXP_CEV_OFF) ||
                           count_reset_set || count_start_set;  // R20
    next_counter_value   = counter_value;
    if (counter_enabled && cev_raw && !cev_prev && counter_value != '1)
      next_counter_value = counter_value + 16'h0001;          // R21
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      cev_prev        <= 1'b0;
      counter_enabled <= 1'b0;
      counter_value   <= '0;
    end else begin
      cev_prev        <= next_cev_prev;
      counter_enabled <= next_counter_enabled;
      counter_value   <= next_counter_value;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_pulse_end;
    state == TRGEXP_PULSE && !trig_level;
  endsequence
  chk_exp_window: assert property (@(posedge clock) disable iff (reset) // R17
    exposure_select == TRGEXP_EXP_TIMED |-> exp_len >= EXP_MIN_US && exp_len <= EXP_MAX_US)
    else $error("exposure length outside window");
  chk_readout_ignore: assert property (@(posedge clock) disable iff (reset) // R11
    state == TRGEXP_IDLE && sensor_readout && !readout_trigger_accept && triggered
    |=> state != TRGEXP_DELAY && state != TRGEXP_PULSE)
    else $error("trigger taken during readout");
  chk_pulse_ends: assert property (@(posedge clock) disable iff (reset) // R16
    s_pulse_end |=> state == TRGEXP_GAP ##1 !exposure_active)
    else $error("pulse exposure did not end");
  chk_capture_gate: assert property (@(posedge clock) disable iff (reset) // R22
    !capture_running && state == TRGEXP_IDLE |=> state == TRGEXP_IDLE)
    else $error("exposure started without capture");
  chk_delay_hold: assert property (@(posedge clock) disable iff (reset) // R14
    state == TRGEXP_DELAY && us_cnt < EXP_W'(trigger_delay_us) |=> state == TRGEXP_DELAY)
    else $error("delay ended early");
  chk_line_wait: assert property (@(posedge clock) disable iff (reset) // R13
    state == TRGEXP_LINE_WAIT && line_valid_timing |=> state == TRGEXP_EXPOSE)
    else $error("line sync start missed");
  chk_cnt_enable: assert property (@(posedge clock) disable iff (reset) // R20
    count_event_select == TRGEXP_CEV_OFF && !count_reset_set && !count_start_set
    |=> !counter_enabled)
    else $error("counter enabled without source");
  chk_cnt_step: assert property (@(posedge clock) disable iff (reset) // R21
    counter_enabled && cev_raw && !cev_prev && counter_value != '1
    |=> counter_value == $past(counter_value) + 16'h0001)
    else $error("counter did not advance");
  chk_pol_first: assert property (@(posedge clock) disable iff (reset) // R7
    !polarity_set && power_up_polarity == TRGEXP_POL_FALL_FIRST |=> ttl_active_low)
    else $error("power-up polarity not applied");
endmodule
`default_nettype wire

/* sim/trgexp_partner.sv */
// Behavioural model of the trigger line and the image sensor readout
`timescale 1ns/1ps
`default_nettype none
module trgexp_partner #(
  parameter int READ_CYC = 60
) (
  // Clock
  input  wire logic clock,
  // From the block and the bench
  input  wire logic exposure_active,
  input  wire logic read_go,
  // To the block
  output logic      line_ttl_in1,
  output logic      sensor_readout,
  output logic      line_valid_timing
);
  // ----
  // Readout
  // ----
  logic was_exp;
  int   left;
  initial line_ttl_in1 = 1'b0;
  initial was_exp = 1'b0;
  initial left = 0;
  // Readout follows every exposure end, or a bench request
  always @(posedge clock) begin
    was_exp <= exposure_active;
    if ((was_exp && !exposure_active) || read_go) begin
      left <= READ_CYC;
    end else if (left > 0) begin
      left <= left - 1;
    end
  end
  always_comb sensor_readout = (left > 0);
  // Line timing runs only during readout, idles low
  always_comb line_valid_timing = (left > 0) && left[2];
  task automatic set_line(input logic v);
    @(posedge clock);
    line_ttl_in1 <= v;
  endtask
endmodule
`default_nettype wire

/* sim/trgexp_core_test.sv */
// Self-checking bench for the trigger and exposure block
`timescale 1ns/1ps
`default_nettype none
module trgexp_core_test
  import trgexp_pkg::*;
;
  logic               clock, reset, read_go, line_ttl_in1, sensor_readout, line_valid_timing;
  logic               frame_begin_trigger, readout_trigger_accept, auto_level_control;
  logic               acq_trigger, acq_start, acq_end, capture_running, count_start_set;
  logic               exposure_active, free_running, trigger_ignored, ttl_active_low, counter_enabled;
  logic [14:0]        srcs;
  logic [DELAY_W-1:0] trigger_delay_us;
  logic [PRIO_N-1:0]  ttl_user_mask, ttl_user_low;
  logic [EXP_W-1:0]   exposure_duration, exposure_used;
  logic [CNT_W-1:0]   counter_value;
  trgexp_src_t        frame_src;
  trgexp_qual_t       trigger_qualifier;
  trgexp_pol_t        power_up_polarity;
  trgexp_exp_t        exposure_select;
  trgexp_auto_t       auto_exposure;
  trgexp_cev_t        count_event_select;
  int                 errors, n_compared, cycles;
  trgexp_partner #(.READ_CYC(60)) i_part (.clock, .exposure_active, .read_go, .line_ttl_in1,
    .sensor_readout, .line_valid_timing);
  trgexp_core i_dut (.clock, .reset, .line_opt_in1(srcs[0]), .line_opt_in2(srcs[1]), .line_ttl_in1,
    .soft_trigger(srcs[3]), .timer_start(srcs[4]), .timer_end(srcs[5]), .timer_active(srcs[6]),
    .counter_start(srcs[7]), .counter_end(srcs[8]), .user_output(srcs[12:9]), .action1(srcs[13]),
    .action2(srcs[14]), .frame_src, .trigger_qualifier, .frame_begin_trigger, .readout_trigger_accept,
    .trigger_delay_us, .power_up_polarity, .ttl_user_mask, .ttl_user_low, .exposure_select,
    .exposure_duration, .auto_exposure, .auto_max_us(EXP_MAX_US), .auto_min_us(EXP_MIN_US),
    .auto_speed(4'h1), .auto_level_control, .auto_too_dark(auto_level_control), .count_event_select,
    .count_reset_set(1'b0), .count_start_set, .acq_trigger, .acq_start, .acq_end,
    .capture_running, .sensor_readout, .line_valid_timing, .exposure_active, .free_running,
    .trigger_ignored, .ttl_active_low, .exposure_used, .counter_enabled, .counter_value);
  always #20 clock = ~clock;
  // Hang guard, far above the run's length
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (errors == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", name, want, seen);
    end
  endtask
  task automatic wait_exp(input logic v, input int n);
    int k;
    k = 0;
    while (exposure_active !== v && k < n) begin
      @(negedge clock);
      k++;
    end
    check("exposure_active", exposure_active, v);
  endtask
  task automatic drive_src(input int i, input logic v);
    if (i == 2) begin
      i_part.set_line(v);
    end else begin
      @(posedge clock);
      srcs[i] <= v;
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic do_reset(input trgexp_pol_t p, input logic [7:0] m, input logic [7:0] l, input logic e);
    @(posedge clock);
    reset <= 1'b1;
    power_up_polarity <= p;
    ttl_user_mask <= m;
    ttl_user_low <= l;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(negedge clock);
    check("ttl_active_low", ttl_active_low, e);
    check("exposure_used", exposure_used, 21'h0003E8);
    check("counter_enabled", counter_enabled, 1'b0);
  endtask
  task automatic t_pulse();
    @(posedge clock);
    exposure_select <= TRGEXP_EXP_PULSE;
    trigger_qualifier <= TRGEXP_LEVEL_HIGH;
    frame_begin_trigger <= 1'b1;
    capture_running <= 1'b1;
    auto_exposure <= TRGEXP_AUTO_CONT;
    for (int i = 0; i < 15; i++) begin
      @(posedge clock);
      frame_src <= trgexp_src_t'(i);
      repeat (4) @(posedge clock);
      drive_src(i, 1'b1);
      wait_exp(1'b1, 12);
      repeat (20) @(negedge clock);
      check("pulse_hold", exposure_active, 1'b1);
      drive_src(i, 1'b0);
      wait_exp(1'b0, 12);
      repeat (80) @(posedge clock);
    end
  endtask
  task automatic t_timed();
    int n;
    n = 0;
    @(posedge clock);
    exposure_select <= TRGEXP_EXP_TIMED;
    trigger_qualifier <= TRGEXP_FALLING;
    frame_src <= TRGEXP_SRC_LINE7;
    trigger_delay_us <= 16'h0002;
    exposure_duration <= 21'h000005;
    auto_exposure <= TRGEXP_AUTO_OFF;
    auto_level_control <= 1'b1;
    i_part.set_line(1'b1);
    repeat (20) @(negedge clock);
    check("ttl_active_low", ttl_active_low, 1'b1);
    check("exposure_active", exposure_active, 1'b0);
    i_part.set_line(1'b0);
    repeat (40) @(negedge clock);
    check("exposure_active", exposure_active, 1'b0);
    wait_exp(1'b1, 40);
    while (exposure_active === 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("exposure_len", (n >= 245 && n <= 280), 1'b1);
    check("exposure_used", exposure_used, 21'h00000A);
    repeat (80) @(posedge clock);
  endtask
  task automatic t_overlap();
    logic seen;
    @(posedge clock);
    frame_src <= TRGEXP_SRC_SOFT;
    trigger_qualifier <= TRGEXP_RISING;
    trigger_delay_us <= 16'h0000;
    for (int a = 0; a < 2; a++) begin
      seen = 1'b0;
      readout_trigger_accept <= a[0];
      read_go <= 1'b1;
      @(posedge clock);
      read_go <= 1'b0;
      repeat (5) @(posedge clock);
      srcs[3] <= 1'b1;
      repeat (6) begin
        @(negedge clock);
        seen = seen | trigger_ignored;
      end
      @(posedge clock);
      srcs[3] <= 1'b0;
      if (a == 0) begin
        check("trigger_ignored", seen, 1'b1);
        repeat (100) @(negedge clock);
        check("exposure_active", exposure_active, 1'b0);
      end else begin
        check("trigger_ignored", seen, 1'b0);
        wait_exp(1'b1, 12);
        wait_exp(1'b0, 400);
        repeat (80) @(posedge clock);
      end
    end
  endtask
  task automatic t_count();
    @(posedge clock);
    count_start_set <= 1'b1;
    repeat (3) @(negedge clock);
    check("counter_enabled", counter_enabled, 1'b1);
    @(posedge clock);
    count_start_set <= 1'b0;
    count_event_select <= TRGEXP_CEV_ACQ_START;
    // Only the chosen source may advance the count
    for (int k = 0; k < 5; k++) begin
      @(posedge clock);
      acq_start <= (k < 3);
      acq_trigger <= (k >= 3);
      acq_end <= 1'b1;
      @(posedge clock);
      {acq_start, acq_trigger, acq_end} <= 3'h0;
    end
    repeat (3) @(negedge clock);
    check("counter_enabled", counter_enabled, 1'b1);
    check("counter_value", counter_value, 16'h0003);
  endtask
  task automatic t_free();
    @(posedge clock);
    exposure_select <= TRGEXP_EXP_OFF;
    repeat (3) @(negedge clock);
    check("free_running", free_running, 1'b1);
    @(posedge clock);
    capture_running <= 1'b0;
    repeat (3) @(negedge clock);
    check("free_running", free_running, 1'b0);
    @(posedge clock);
    capture_running <= 1'b1;
    exposure_select <= TRGEXP_EXP_TIMED;
    frame_begin_trigger <= 1'b0;
    repeat (3) @(negedge clock);
    check("free_running", free_running, 1'b1);
  endtask
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    srcs = '0;
    {read_go, frame_begin_trigger, readout_trigger_accept, auto_level_control} = '0;
    {acq_trigger, acq_start, acq_end, capture_running, count_start_set, errors, n_compared, cycles} = '0;
    trigger_delay_us = '0;
    {ttl_user_mask, ttl_user_low} = '0;
    exposure_duration = 21'h0003E8;
    frame_src = TRGEXP_SRC_OFF;
    trigger_qualifier = TRGEXP_RISING;
    power_up_polarity = TRGEXP_POL_AUTO;
    exposure_select = TRGEXP_EXP_OFF;
    auto_exposure = TRGEXP_AUTO_OFF;
    count_event_select = TRGEXP_CEV_OFF;
    do_reset(TRGEXP_POL_FALL_FIRST, 8'h00, 8'h00, 1'b1);
    do_reset(TRGEXP_POL_RISE_FIRST, 8'h00, 8'hFF, 1'b0);
    do_reset(TRGEXP_POL_AUTO, 8'h06, 8'h02, 1'b1);
    do_reset(TRGEXP_POL_AUTO, 8'h06, 8'h04, 1'b0);
    t_pulse();
    t_timed();
    t_overlap();
    t_count();
    t_free();
    stop_test();
  end
endmodule
`default_nettype wire
